// [logic/tmwg_presc.sv]
// Prescaler that turns the peripheral clock into count ticks.
`timescale 1ns/1ps
`default_nettype none
module tmwg_presc
  import tmwg_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic    i_clk_sys,
  input  wire logic    i_rst,
  input  wire logic    i_ce,
  // Tick link to the core.
  tmwg_tick_if.src     t
);
  logic [TMWG_DIVW-1:0] div_cnt_r;
  logic [TMWG_DIVW-1:0] div_cnt_nxt;
  logic [TMWG_DIVW-1:0] div_last;

  // The tick fires on the last count of each divider period.
  assign div_last = TMWG_DIV[t.sel] - 11'h001;
  assign t.tick   = t.run && !t.clr && (div_cnt_r >= div_last);

  // Next divider count; a restart or a stopped timer clears it.
  always_comb begin
    div_cnt_nxt = div_cnt_r;
    if (!t.run || t.clr || t.tick) begin
      div_cnt_nxt = '0;
    end else begin
      div_cnt_nxt = div_cnt_r + 11'h001;
    end
  end

  // Divider count register, frozen while the clock enable is low.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      div_cnt_r <= '0;
    end else if (i_ce) begin
      div_cnt_r <= div_cnt_nxt;
    end
  end
endmodule : tmwg_presc
`default_nettype wire

// [logic/tmwg_top.sv]
// Timer waveform generator core with APB registers, counter, compare channels and pin override.
//
// Overview of operation
// - Frequency mode: period from compare zero, toggle.
// - Frequency mode output is clock over 2N(C0+1).
// - Channels one, two toggle at same frequency.
// - Phase follows direction and compare versus count.
// - Single slope: count up, set zero, clear match.
// - Single slope: compare zero low, above period high.
// - Single slope period is N times period plus one.
// - Dual slope: up then down, clear/set on match.
// - Dual slope: zero low, equal period high.
// - Dual slope period is twice N times period.
// - Enabled channel in waveform mode overrides pin.
// - Inverted pin drives complement of the waveform.
// - Command write acts at once.
// - Update command transfers buffers despite lock.
// - Restart zeroes counter and all waveforms.
// - Reset command only honoured while timer disabled.
// - Update condition transfers valid buffers unless locked.
// - Compare match sets channel flag next cycle.
`timescale 1ns/1ps
`default_nettype none
module tmwg_top
  import tmwg_pkg::*;
#(
  parameter int W = TMWG_W
) (
  // Clock, reset and enable.
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_rst,
  input  wire logic                 i_ce,
  // APB slave.
  input  wire logic                 i_psel,
  input  wire logic                 i_penable,
  input  wire logic                 i_pwrite,
  input  wire logic [TMWG_AW-1:0]   i_paddr,
  input  wire logic [TMWG_DW-1:0]   i_pwdata,
  output logic      [TMWG_DW-1:0]   o_prdata,
  output logic                      o_pready,
  output logic                      o_pslverr,
  // Port pins.
  output logic      [TMWG_NCH-1:0]  o_pin_out,
  output logic      [TMWG_NCH-1:0]  o_pin_oe
);
  // Configuration state.
  logic                enable_r, enable_nxt;
  logic [2:0]          prescale_select_r, prescale_select_nxt;
  tmwg_mode_t          mode_r, mode_nxt;
  logic [TMWG_NCH-1:0] channel_output_enable_r, channel_output_enable_nxt;
  logic                count_down_r, count_down_nxt;
  logic                update_lock_r, update_lock_nxt;
  // Counter, period and compare state.
  logic [W-1:0]        counter_value_r, counter_value_nxt;
  logic [W-1:0]        per_r, per_nxt, perbuf_r, perbuf_nxt;
  logic                perbv_r, perbv_nxt;
  logic [W-1:0]        cmp_r [TMWG_NCH];
  logic [W-1:0]        cmp_nxt [TMWG_NCH];
  logic [W-1:0]        cmpbuf_r [TMWG_NCH];
  logic [W-1:0]        cmpbuf_nxt [TMWG_NCH];
  logic [TMWG_NCH-1:0] cmpbv_r, cmpbv_nxt;
  logic                slope_down_r, slope_down_nxt;
  logic [TMWG_NCH-1:0] wave_r, wave_nxt;
  logic [TMWG_NCH-1:0] flag_r, flag_nxt;
  // Port state.
  logic [TMWG_NCH-1:0] pin_direction_r, pin_direction_nxt;
  logic [TMWG_NCH-1:0] pin_output_value_r, pin_output_value_nxt;
  logic [TMWG_NCH-1:0] pin_invert_enable_r, pin_invert_enable_nxt;
  logic [TMWG_NCH-1:0] pin_out_r, pin_out_nxt;
  logic [TMWG_NCH-1:0] pin_oe_r, pin_oe_nxt;
  // Bus answer state.
  logic [TMWG_DW-1:0]  prdata_r, prdata_nxt;
  logic                pready_r, pready_nxt;
  logic                pslverr_r, pslverr_nxt;
  // Decoded strobes.
  logic                wr, rd, hit, upd_evt, wrap;
  logic                cmd_update, cmd_restart, cmd_reset;
  logic [W-1:0]        top;
  logic [TMWG_NCH-1:0] match;
  logic [TMWG_DW-1:0]  rdata;
  logic [1:0]          cmd_field;

  tmwg_tick_if tk ();

  // Prescaler feeding count ticks.
  assign tk.sel = prescale_select_r;
  assign tk.run = enable_r;
  assign tk.clr = cmd_restart;

  tmwg_presc u_presc (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_ce      (i_ce),
    .t         (tk)
  );

  // Access strobes; the write acts at the access edge with pready high, the read at the setup edge with pready low.
  assign wr        = i_psel && i_penable && pready_r && i_pwrite;
  assign rd        = i_psel && !i_penable && !pready_r && !i_pwrite;
  assign cmd_field = i_pwdata[TMWG_CMD_LSB +: 2];
  assign cmd_update  = wr && (i_paddr == TMWG_OFS_CSET) && (cmd_field == TMWG_CMD_UPDATE);
  assign cmd_restart = wr && (i_paddr == TMWG_OFS_CSET) && (cmd_field == TMWG_CMD_RESTART);
  assign cmd_reset   = wr && (i_paddr == TMWG_OFS_CSET) && (cmd_field == TMWG_CMD_RESET)
                       && !enable_r;
  // In frequency mode compare zero sets the top of the count.
  assign top = (mode_r == TMWG_FREQ) ? cmp_r[0] : per_r;

  // Per-channel match and waveform/pin next values.
  for (genvar n = 0; n < TMWG_NCH; n++) begin : g_ch
    assign match[n] = (counter_value_r == cmp_r[n]);
    always_comb begin
      wave_nxt[n] = wave_r[n];
      if (cmd_restart) begin
        wave_nxt[n] = 1'b0;
      end else if (mode_r == TMWG_FREQ) begin
        if (enable_r && tk.tick && match[n]) begin
          wave_nxt[n] = !wave_r[n];
        end
      end else if (mode_r == TMWG_SINGLE) begin
        wave_nxt[n] = (counter_value_nxt < cmp_nxt[n]);
      end else if (mode_r == TMWG_DUAL) begin
        wave_nxt[n] = (counter_value_nxt < cmp_nxt[n])
                      || ((cmp_nxt[n] == per_nxt) && (cmp_nxt[n] != '0));
      end
      // Flag sets one cycle after the match; the set wins over a clear.
      flag_nxt[n] = flag_r[n];
      if (wr && (i_paddr == TMWG_OFS_STAT) && i_pwdata[TMWG_FLAG_LSB + n]) begin
        flag_nxt[n] = 1'b0;
      end
      if (enable_r && tk.tick && match[n]) begin
        flag_nxt[n] = 1'b1;
      end
      // Enabled channel in a waveform mode replaces the port value.
      pin_out_nxt[n] = ((channel_output_enable_r[n] && (mode_r != TMWG_NORMAL))
                        ? wave_r[n] : pin_output_value_r[n]) ^ pin_invert_enable_r[n];
      pin_oe_nxt[n]  = pin_direction_r[n];
    end
  end

  // Read multiplexer.
  always_comb begin
    hit   = 1'b1;
    rdata = '0;
    if (i_paddr == TMWG_OFS_CTRLA) begin
      rdata[TMWG_EN_BIT]       = enable_r;
      rdata[TMWG_PSC_LSB +: 3] = prescale_select_r;
    end else if (i_paddr == TMWG_OFS_CTRLB) begin
      rdata[TMWG_MODE_LSB +: 2]        = mode_r;
      rdata[TMWG_CHEN_LSB +: TMWG_NCH] = channel_output_enable_r;
    end else if (i_paddr == TMWG_OFS_CTRLE) begin
      rdata[TMWG_DOWN_BIT] = count_down_r;
      rdata[TMWG_LOCK_BIT] = update_lock_r;
    end else if (i_paddr == TMWG_OFS_CSET) begin
      rdata = '0;
    end else if (i_paddr == TMWG_OFS_CNT) begin
      rdata[W-1:0] = counter_value_r;
    end else if (i_paddr == TMWG_OFS_PER) begin
      rdata[W-1:0] = per_r;
    end else if (i_paddr == TMWG_OFS_PERBUF) begin
      rdata[W-1:0] = perbuf_r;
    end else if (i_paddr == TMWG_OFS_CMP || i_paddr == TMWG_OFS_CMP + 8'h04
                 || i_paddr == TMWG_OFS_CMP + 8'h08) begin
      rdata[W-1:0] = cmp_r[i_paddr[3:2]];
    end else if (i_paddr == TMWG_OFS_CMPBUF || i_paddr == TMWG_OFS_CMPBUF + 8'h04
                 || i_paddr == TMWG_OFS_CMPBUF + 8'h08) begin
      rdata[W-1:0] = cmpbuf_r[i_paddr[3:2]];
    end else if (i_paddr == TMWG_OFS_STAT) begin
      rdata[TMWG_FLAG_LSB +: TMWG_NCH]  = flag_r;
      rdata[TMWG_WAVE_LSB +: TMWG_NCH]  = wave_r;
      rdata[TMWG_CMPBV_LSB +: TMWG_NCH] = cmpbv_r;
      rdata[TMWG_PERBV_BIT]             = perbv_r;
    end else if (i_paddr == TMWG_OFS_PORT) begin
      rdata[TMWG_PDIR_LSB +: TMWG_NCH] = pin_direction_r;
      rdata[TMWG_POUT_LSB +: TMWG_NCH] = pin_output_value_r;
      rdata[TMWG_PINV_LSB +: TMWG_NCH] = pin_invert_enable_r;
    end else begin
      hit = 1'b0;
    end
  end

  // Next values of bus answer, configuration, counter and buffers.
  always_comb begin
    pready_nxt  = i_psel && !i_penable && !pready_r;
    pslverr_nxt = i_psel && !i_penable && !pready_r && !hit;
    prdata_nxt  = rd ? rdata : '0;
    enable_nxt = enable_r;
    prescale_select_nxt = prescale_select_r;
    mode_nxt = mode_r;
    channel_output_enable_nxt = channel_output_enable_r;
    count_down_nxt = count_down_r;
    update_lock_nxt = update_lock_r;
    counter_value_nxt = counter_value_r;
    slope_down_nxt = slope_down_r;
    per_nxt = per_r;
    perbuf_nxt = perbuf_r;
    perbv_nxt = perbv_r;
    cmp_nxt = cmp_r;
    cmpbuf_nxt = cmpbuf_r;
    cmpbv_nxt = cmpbv_r;
    pin_direction_nxt = pin_direction_r;
    pin_output_value_nxt = pin_output_value_r;
    pin_invert_enable_nxt = pin_invert_enable_r;
    wrap = 1'b0;
    // Counting; single slope ignores the down bit, dual slope turns at the ends.
    if (enable_r && tk.tick) begin
      if (mode_r == TMWG_DUAL) begin
        if (!slope_down_r) begin
          if (counter_value_r >= top) begin
            slope_down_nxt    = 1'b1;
            counter_value_nxt = counter_value_r - 16'h0001;
          end else begin
            counter_value_nxt = counter_value_r + 16'h0001;
          end
        end else if (counter_value_r <= 16'h0001) begin
          slope_down_nxt    = 1'b0;
          counter_value_nxt = '0;
          wrap              = 1'b1;
        end else begin
          counter_value_nxt = counter_value_r - 16'h0001;
        end
      end else if (count_down_r && (mode_r != TMWG_SINGLE)) begin
        wrap              = (counter_value_r == '0);
        counter_value_nxt = wrap ? top : counter_value_r - 16'h0001;
      end else begin
        wrap              = (counter_value_r == top);
        counter_value_nxt = wrap ? '0 : counter_value_r + 16'h0001;
      end
    end
    // Buffer transfers on the update condition or command.
    upd_evt = (wrap && !update_lock_r) || cmd_update;
    if (upd_evt && perbv_r) begin
      per_nxt   = perbuf_r;
      perbv_nxt = 1'b0;
    end
    for (int n = 0; n < TMWG_NCH; n++) begin
      if (upd_evt && cmpbv_r[n]) begin
        cmp_nxt[n]   = cmpbuf_r[n];
        cmpbv_nxt[n] = 1'b0;
      end
    end
    // Register writes; a counter write beats counting.
    if (wr) begin
      if (i_paddr == TMWG_OFS_CTRLA) begin
        enable_nxt          = i_pwdata[TMWG_EN_BIT];
        prescale_select_nxt = i_pwdata[TMWG_PSC_LSB +: 3];
      end else if (i_paddr == TMWG_OFS_CTRLB) begin
        mode_nxt                  = tmwg_mode_t'(i_pwdata[TMWG_MODE_LSB +: 2]);
        channel_output_enable_nxt = i_pwdata[TMWG_CHEN_LSB +: TMWG_NCH];
      end else if (i_paddr == TMWG_OFS_CTRLE) begin
        count_down_nxt  = i_pwdata[TMWG_DOWN_BIT];
        update_lock_nxt = i_pwdata[TMWG_LOCK_BIT];
      end else if (i_paddr == TMWG_OFS_CNT) begin
        counter_value_nxt = i_pwdata[W-1:0];
      end else if (i_paddr == TMWG_OFS_PER) begin
        per_nxt = i_pwdata[W-1:0];
      end else if (i_paddr == TMWG_OFS_PERBUF) begin
        perbuf_nxt = i_pwdata[W-1:0];
        perbv_nxt  = 1'b1;
      end else if (i_paddr[7:4] == TMWG_OFS_CMP[7:4] && i_paddr[3:2] != 2'h3) begin
        cmp_nxt[i_paddr[3:2]] = i_pwdata[W-1:0];
      end else if (i_paddr[7:4] == TMWG_OFS_CMPBUF[7:4] && i_paddr[3:2] != 2'h3) begin
        cmpbuf_nxt[i_paddr[3:2]] = i_pwdata[W-1:0];
        cmpbv_nxt[i_paddr[3:2]]  = 1'b1;
      end else if (i_paddr == TMWG_OFS_PORT) begin
        pin_direction_nxt     = i_pwdata[TMWG_PDIR_LSB +: TMWG_NCH];
        pin_output_value_nxt  = i_pwdata[TMWG_POUT_LSB +: TMWG_NCH];
        pin_invert_enable_nxt = i_pwdata[TMWG_PINV_LSB +: TMWG_NCH];
      end
    end
    // Restart starts a fresh period from zero.
    if (cmd_restart) begin
      counter_value_nxt = '0;
      slope_down_nxt    = 1'b0;
    end
    // Reset command returns control, counter, period and compare registers to their initial values.
    if (cmd_reset) begin
      prescale_select_nxt       = '0;
      mode_nxt                  = TMWG_NORMAL;
      channel_output_enable_nxt = '0;
      count_down_nxt            = 1'b0;
      update_lock_nxt           = 1'b0;
      counter_value_nxt         = TMWG_CNT_RST;
      slope_down_nxt            = 1'b0;
      per_nxt                   = TMWG_PER_RST;
      perbuf_nxt                = TMWG_PER_RST;
      perbv_nxt                 = 1'b0;
      cmpbv_nxt                 = '0;
      for (int n = 0; n < TMWG_NCH; n++) begin
        cmp_nxt[n]    = TMWG_CMP_RST;
        cmpbuf_nxt[n] = TMWG_CMP_RST;
      end
    end
  end

  // State registers; everything holds while the clock enable is low.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      enable_r <= 1'b0;
      prescale_select_r <= '0;
      mode_r <= TMWG_NORMAL;
      channel_output_enable_r <= '0;
      count_down_r <= 1'b0;
      update_lock_r <= 1'b0;
      counter_value_r <= TMWG_CNT_RST;
      slope_down_r <= 1'b0;
      per_r <= TMWG_PER_RST;
      perbuf_r <= TMWG_PER_RST;
      perbv_r <= 1'b0;
      cmp_r <= '{default: TMWG_CMP_RST};
      cmpbuf_r <= '{default: TMWG_CMP_RST};
      cmpbv_r <= '0;
      wave_r <= '0;
      flag_r <= '0;
      pin_direction_r <= '0;
      pin_output_value_r <= '0;
      pin_invert_enable_r <= '0;
      pin_out_r <= '0;
      pin_oe_r <= '0;
      prdata_r <= '0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else if (i_ce) begin
      enable_r <= enable_nxt;
      prescale_select_r <= prescale_select_nxt;
      mode_r <= mode_nxt;
      channel_output_enable_r <= channel_output_enable_nxt;
      count_down_r <= count_down_nxt;
      update_lock_r <= update_lock_nxt;
      counter_value_r <= counter_value_nxt;
      slope_down_r <= slope_down_nxt;
      per_r <= per_nxt;
      perbuf_r <= perbuf_nxt;
      perbv_r <= perbv_nxt;
      cmp_r <= cmp_nxt;
      cmpbuf_r <= cmpbuf_nxt;
      cmpbv_r <= cmpbv_nxt;
      wave_r <= wave_nxt;
      flag_r <= flag_nxt;
      pin_direction_r <= pin_direction_nxt;
      pin_output_value_r <= pin_output_value_nxt;
      pin_invert_enable_r <= pin_invert_enable_nxt;
      pin_out_r <= pin_out_nxt;
      pin_oe_r <= pin_oe_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Outputs straight from flip-flops.
  assign o_prdata  = prdata_r;
  assign o_pready  = pready_r;
  assign o_pslverr = pslverr_r;
  assign o_pin_out = pin_out_r;
  assign o_pin_oe  = pin_oe_r;

  // Checks on the waveform, command, buffer update, flag and pin behaviour.
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  sequence s_quiet;
    i_ce && !wr;
  endsequence

  // The waveform bit after a quiet single or dual slope cycle follows the count and compare it lands with.
  sequence s_single_c1_zero;
    ((mode_r == TMWG_SINGLE) && (cmp_r[1] == '0)) and s_quiet;
  endsequence

  sequence s_dual_c2_top;
    ((mode_r == TMWG_DUAL) && (cmp_r[2] == per_r) && (per_r != '0)) and s_quiet;
  endsequence

  a_freq_toggle: assert property (((mode_r == TMWG_FREQ) && enable_r && tk.tick && match[1]) and s_quiet
    |=> wave_r[1] != $past(wave_r[1])) else $error("frequency output did not toggle on match");
  a_single_wrap: assert property (((mode_r == TMWG_SINGLE) && enable_r && tk.tick && (counter_value_r == per_r))
    and s_quiet |=> counter_value_r == '0) else $error("single slope did not restart at zero");
  a_single_low: assert property (s_single_c1_zero
    |=> (cmp_r[1] != '0) || !wave_r[1]) else $error("compare zero did not hold output low");
  a_single_high: assert property (((mode_r == TMWG_SINGLE) && (cmp_r[2] > per_r)) and s_quiet
    |=> wave_r[2]) else $error("compare above period did not hold output high");
  a_dual_high: assert property (s_dual_c2_top
    |=> (cmp_r[2] != per_r) || (per_r == '0) || wave_r[2]) else $error("dual slope compare at top did not hold high");
  a_restart_zero: assert property (cmd_restart && i_ce
    |=> (counter_value_r == '0) && (wave_r == '0)) else $error("restart left count or output set");
  a_reset_ignored: assert property (wr && (i_paddr == TMWG_OFS_CSET) && enable_r && i_ce
    && (cmd_field == TMWG_CMD_RESET) |=> enable_r && $stable(per_r)) else $error("reset acted while running");
  a_update_cmd: assert property (cmd_update && perbv_r && i_ce
    |=> (per_r == $past(perbuf_r)) && !perbv_r) else $error("update command skipped transfer");
  a_lock_hold: assert property ((update_lock_r && wrap && perbv_r) and s_quiet
    |=> perbv_r && $stable(per_r)) else $error("locked update moved the buffer");
  a_flag_next: assert property (enable_r && tk.tick && match[2] && i_ce
    |=> flag_r[2]) else $error("compare match flag not set");
  a_pin_invert: assert property (i_ce && channel_output_enable_r[0] && (mode_r != TMWG_NORMAL) && pin_invert_enable_r[0]
    |=> o_pin_out[0] == !$past(wave_r[0])) else $error("inverted pin not complement of waveform");
endmodule : tmwg_top
`default_nettype wire

// [pkg/tmwg_pkg.sv]
// Package with register map, field layout, reset values and enums of the timer waveform generator.
package tmwg_pkg;
  // Data widths and channel count.
  localparam int TMWG_W     = 16;
  localparam int TMWG_NCH   = 3;
  localparam int TMWG_AW    = 8;
  localparam int TMWG_DW    = 32;
  localparam int TMWG_DIVW  = 11;

  // Waveform modes and software commands.
  typedef enum logic [1:0] {TMWG_NORMAL, TMWG_FREQ, TMWG_SINGLE, TMWG_DUAL} tmwg_mode_t;
  typedef enum logic [1:0] {TMWG_CMD_NONE, TMWG_CMD_UPDATE, TMWG_CMD_RESTART, TMWG_CMD_RESET} tmwg_cmd_t;

  // Register byte offsets.
  localparam logic [TMWG_AW-1:0] TMWG_OFS_CTRLA  = 8'h00;
  localparam logic [TMWG_AW-1:0] TMWG_OFS_CTRLB  = 8'h04;
  localparam logic [TMWG_AW-1:0] TMWG_OFS_CTRLE  = 8'h08;
  localparam logic [TMWG_AW-1:0] TMWG_OFS_CSET   = 8'h0c;
  localparam logic [TMWG_AW-1:0] TMWG_OFS_CNT    = 8'h10;
  localparam logic [TMWG_AW-1:0] TMWG_OFS_PER    = 8'h14;
  localparam logic [TMWG_AW-1:0] TMWG_OFS_PERBUF = 8'h18;
  localparam logic [TMWG_AW-1:0] TMWG_OFS_CMP    = 8'h20;
  localparam logic [TMWG_AW-1:0] TMWG_OFS_CMPBUF = 8'h30;
  localparam logic [TMWG_AW-1:0] TMWG_OFS_STAT   = 8'h40;
  localparam logic [TMWG_AW-1:0] TMWG_OFS_PORT   = 8'h44;

  // Field positions.
  localparam int TMWG_EN_BIT    = 0;
  localparam int TMWG_PSC_LSB   = 1;
  localparam int TMWG_MODE_LSB  = 0;
  localparam int TMWG_CHEN_LSB  = 4;
  localparam int TMWG_DOWN_BIT  = 0;
  localparam int TMWG_LOCK_BIT  = 1;
  localparam int TMWG_CMD_LSB   = 0;
  localparam int TMWG_FLAG_LSB  = 0;
  localparam int TMWG_WAVE_LSB  = 4;
  localparam int TMWG_CMPBV_LSB = 8;
  localparam int TMWG_PERBV_BIT = 11;
  localparam int TMWG_PDIR_LSB  = 0;
  localparam int TMWG_POUT_LSB  = 4;
  localparam int TMWG_PINV_LSB  = 8;

  // Reset values.
  localparam logic [TMWG_W-1:0] TMWG_PER_RST = 16'hffff;
  localparam logic [TMWG_W-1:0] TMWG_CMP_RST = 16'h0000;
  localparam logic [TMWG_W-1:0] TMWG_CNT_RST = 16'h0000;

  // Prescale dividers per select code; code zero divides by one.
  localparam logic [TMWG_DIVW-1:0] TMWG_DIV [0:7] = '{11'h001, 11'h002, 11'h004, 11'h008,
                                                    11'h010, 11'h040, 11'h100, 11'h400};
endpackage : tmwg_pkg

// [pkg/tmwg_tick_if.sv]
// Interface carrying prescaler control and count tick between the core and the prescaler.
`timescale 1ns/1ps
`default_nettype none
interface tmwg_tick_if;
  logic [2:0] sel;
  logic       run;
  logic       clr;
  logic       tick;
  modport src (input sel, input run, input clr, output tick);
  modport dst (output sel, output run, output clr, input tick);
endinterface : tmwg_tick_if
`default_nettype wire

// [verif/tb_top.sv]
// Self-checking bench for the timer waveform generator.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tmwg_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, rdy, slv, e;
  logic [7:0]  pa  = 8'h00;
  logic [31:0] pwd = 32'h0, prd, q;
  logic [2:0]  pout, poe, pad;
  int          err_total = 0, checked = 0, hi[3], tr[3];
  // Clock at 100 MHz.
  always #5 clk = ~clk;
  tmwg_top i_tmwg_top (.i_clk_sys(clk), .i_rst(rst), .i_ce(1'b1), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy), .o_pslverr(slv),
    .o_pin_out(pout), .o_pin_oe(poe));
  tmwg_pin_model i_tmwg_pin_model (.i_clk_sys(clk), .i_pin_out(pout), .i_pin_oe(poe), .o_pad(pad));
  // Verdict and end of run.
  task summarize;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  task chk(input string n, input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  // One APB transfer; holds the request until pready is sampled high.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pwr <= w; pa <= a; pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    // The wait ends when pready is high; the watchdog ends it if pready never comes.
    do @(posedge clk); while (rdy !== 1'b1);
    q = prd; e = slv;
    psel <= 1'b0; pen <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask : wr
  task rd(input string n, input logic [7:0] a, input logic [31:0] x); apb(1'b0, a, 32'h0); chk(n, q, x); endtask : rd
  // Restarts, programs a period of three and runs the chosen mode.
  task cfg(input logic [1:0] m, input logic [2:0] ps, input logic [15:0] c0, c1, c2, input logic [2:0] en,
           input logic [10:0] port);
    wr(TMWG_OFS_CTRLA, 32'h0); wr(TMWG_OFS_CSET, 32'h2); wr(TMWG_OFS_PER, 32'h3);
    wr(TMWG_OFS_CMP, {16'h0, c0}); wr(TMWG_OFS_CMP + 8'h04, {16'h0, c1}); wr(TMWG_OFS_CMP + 8'h08, {16'h0, c2});
    wr(TMWG_OFS_CTRLB, {25'h0, en, 2'b00, m}); wr(TMWG_OFS_PORT, {21'h0, port});
    wr(TMWG_OFS_CTRLE, 32'h0);
    wr(TMWG_OFS_CTRLA, {28'h0, ps, 1'b1}); repeat (16) @(posedge clk);
  endtask : cfg
  // Counts high samples and edges of each pad over a window.
  task meas(input int c);
    logic [2:0] p;
    hi = '{0, 0, 0}; tr = '{0, 0, 0};
    @(posedge clk); p = pad;
    repeat (c) begin
      @(posedge clk);
      chk("pad_known", {31'h0, $isunknown(pad)}, 32'h0);
      for (int i = 0; i < 3; i++) begin hi[i] += int'(p[i]); tr[i] += int'(pad[i] != p[i]); end
      p = pad;
    end
  endtask : meas
  task t_cmds;
    rd("per_rst", TMWG_OFS_PER, 32'h0000ffff); rd("cnt_rst", TMWG_OFS_CNT, 32'h0);
    apb(1'b0, 8'hfc, 32'h0); chk("slverr", {31'h0, e}, 32'h1);
    wr(TMWG_OFS_CNT, 32'h5); wr(TMWG_OFS_CSET, 32'h2); rd("cnt", TMWG_OFS_CNT, 32'h0);
    wr(TMWG_OFS_PERBUF, 32'h9); wr(TMWG_OFS_CTRLE, 32'h2); wr(TMWG_OFS_CSET, 32'h1);
    rd("per_upd", TMWG_OFS_PER, 32'h9);
    wr(TMWG_OFS_PERBUF, 32'h5); wr(TMWG_OFS_CTRLA, 32'h1); repeat (24) @(posedge clk);
    rd("per_lock", TMWG_OFS_PER, 32'h9);
    rd("stat_lock", TMWG_OFS_STAT, 32'h807);
    wr(TMWG_OFS_CTRLA, 32'h0); wr(TMWG_OFS_CSET, 32'h1); rd("per_upd2", TMWG_OFS_PER, 32'h5);
    wr(TMWG_OFS_CTRLE, 32'h0); wr(TMWG_OFS_CTRLA, 32'h1); wr(TMWG_OFS_PER, 32'h7); wr(TMWG_OFS_CSET, 32'h3);
    rd("per_run", TMWG_OFS_PER, 32'h7);
    wr(TMWG_OFS_CTRLA, 32'h0); wr(TMWG_OFS_CSET, 32'h3); rd("per_off", TMWG_OFS_PER, 32'h0000ffff);
  endtask : t_cmds
  task t_single;
    cfg(2'd2, 3'd0, 16'h2, 16'h0, 16'h5, 3'h7, 11'h007); meas(24);
    chk("ss_hi0", hi[0], 12); chk("ss_tr0", tr[0], 12);
    chk("ss_hi1", hi[1], 0); chk("ss_hi2", hi[2], 24);
    cfg(2'd2, 3'd1, 16'h2, 16'h0, 16'h5, 3'h7, 11'h007); meas(24); chk("ps_tr0", tr[0], 6);
  endtask : t_single
  task t_dual;
    cfg(2'd3, 3'd0, 16'h2, 16'h0, 16'h3, 3'h7, 11'h007); meas(24);
    chk("ds_hi0", hi[0], 12); chk("ds_tr0", tr[0], 8);
    chk("ds_hi1", hi[1], 0); chk("ds_hi2", hi[2], 24);
  endtask : t_dual
  task t_freq;
    cfg(2'd1, 3'd0, 16'h2, 16'h1, 16'h0, 3'h7, 11'h007); meas(24);
    chk("fq_tr0", tr[0], 8); chk("fq_hi0", hi[0], 12);
    chk("fq_tr1", tr[1], 8); chk("fq_tr2", tr[2], 8);
    cfg(2'd1, 3'd0, 16'h0, 16'h0, 16'h0, 3'h7, 11'h007); meas(24); chk("fq_max", tr[0], 24);
  endtask : t_freq
  task t_pins;
    cfg(2'd2, 3'd0, 16'h1, 16'h0, 16'h0, 3'h1, 11'h147); meas(24);
    chk("inv_hi0", hi[0], 18);
    chk("pin_oe", {29'h0, poe}, 32'h7);
    chk("pin_hi1", hi[1], 0); chk("pin_hi2", hi[2], 24);
  endtask : t_pins
  // Main sequence.
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_cmds; t_single; t_dual; t_freq; t_pins;
    summarize;
  end
  // Watchdog against a hung handshake.
  initial begin
    #100000;
    err_total++;
    summarize;
  end
endmodule : tb_top
`default_nettype wire

// [verif/tmwg_pin_model.sv]
// Model of the port pads that the waveform outputs drive.
`timescale 1ns/1ps
`default_nettype none
module tmwg_pin_model
  import tmwg_pkg::*;
(
  // Clock.
  input  wire logic                i_clk_sys,
  // Pin drive from the block.
  input  wire logic [TMWG_NCH-1:0] i_pin_out,
  input  wire logic [TMWG_NCH-1:0] i_pin_oe,
  // Pad levels.
  output logic      [TMWG_NCH-1:0] o_pad
);
  logic [TMWG_NCH-1:0] last_r;
  // An undriven pad flips its last level each cycle, and stays unknown until it has been driven.
  always_ff @(posedge i_clk_sys) begin
    last_r <= o_pad;
  end
  // Only a pin set as output carries the drive.
  assign o_pad = (i_pin_oe & i_pin_out) | (~i_pin_oe & ~last_r);
endmodule : tmwg_pin_model
`default_nettype wire
